// ==== verilog/tbsc_pkg.sv ====
// constants and shared arithmetic for the three-band soft-knee compressor
package tbsc_pkg;
    localparam int SAMPLE_RATE_HZ = 48000;
    localparam int FREQ_MIN_HZ = 16;
    localparam int FREQ_MAX_HZ = 25088;
    localparam int DLY_MAX_TENTH_MS = 250;
    localparam int DLY_MAX_SAMPLES = SAMPLE_RATE_HZ * DLY_MAX_TENTH_MS / 10000;
    localparam int DLY_DEPTH = DLY_MAX_SAMPLES + 1;
    localparam int GAIN_MIN_TENTH_DB = -790;
    localparam int GAIN_MAX_TENTH_DB = 240;
    localparam int RATIO_MIN_TENTHS = 10;
    localparam int RATIO_MAX_TENTHS = 1000;
    localparam int RATIO_INF = 0;
    localparam int ATK_MAX_TENTH_MS = 2280;
    localparam int REL_MAX_MS = 3000;
    localparam int SMTH_MAX_TENTH_MS = 2280;
    // 2*pi/fs scaled by 2^16 and 2^10
    localparam int COEF_SCALE_Q10 = 8784;
    localparam int COEF_MAX = 65535;
    // tenths of dB to log2 Q8, and back, both scaled by 2^10
    localparam int DB_TO_LOG_Q10 = 4354;
    localparam int LOG_TO_DB_Q10 = 241;
    localparam int KNEE_Q8 = 256;
    localparam int UNITY_Q8 = 256;
    localparam int SILENCE_LOG = -8192;

    function automatic int clampInt(input int v, input int lo, input int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clampInt

    function automatic logic signed [15:0] satS16(input longint v);
        if (v > 32767)
        begin
            return 16'sh7fff;
        end
        if (v < -32768)
        begin
            return 16'sh8000;
        end
        return 16'(v);
    endfunction : satS16

    function automatic int dbToLog(input int tenths);
        return (tenths * DB_TO_LOG_Q10) >>> 10;
    endfunction : dbToLog

    // log2 Q8 gain to linear Q8; far below -24 octaves is simply silence
    function automatic longint exp2Lin(input int lg);
        int n;
        longint base;
        n = lg >>> 8;
        base = longint'(UNITY_Q8 + (lg & 255));
        if (n > 8)
        begin
            n = 8;
        end
        if (n < -24)
        begin
            return 0;
        end
        return (n >= 0) ? (base <<< n) : (base >>> (-n));
    endfunction : exp2Lin

    // one-pole low-pass, state carries 8 fraction bits
    function automatic logic signed [23:0] onePole(input logic signed [23:0] st, input int x, input int coef);
        longint d;
        d = (longint'(x) <<< 8) - longint'(st);
        return 24'(longint'(st) + ((d * coef) >>> 16));
    endfunction : onePole
endpackage : tbsc_pkg

// ==== verilog/tbsc_band_comp.sv ====
// one band's level detector, soft-knee gain computer and gain ballistics
module tbsc_band_comp
    import tbsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic signed [15:0] scL,
    input wire logic signed [15:0] scR,
    input wire logic signed [10:0] thrTenthDb,
    input wire logic [10:0] ratioTenths,
    input wire logic [11:0] atkTenthMs,
    input wire logic [11:0] relMs,
    input wire logic [11:0] smthTenthMs,
    output logic signed [15:0] gainLog,
    output logic [11:0] grTenthDb
);
    typedef struct packed {
        logic signed [23:0] env;
        logic signed [23:0] smth;
        logic signed [15:0] gainLog;
        logic [11:0] grTenthDb;
    } tbsc_bc_state_t;

    tbsc_bc_state_t st_r;
    tbsc_bc_state_t st_nxt;

    function automatic int levelLog(input logic [16:0] v);
        int p;
        int frac;
        p = -1;
        for (int i = 0; i < 17; i++)
        begin
            if (v[i])
            begin
                p = i;
            end
        end
        if (p < 0)
        begin
            return SILENCE_LOG;
        end
        frac = (p >= 8) ? int'(v >> (p - 8)) & 255 : int'(v << (8 - p)) & 255;
        return (p - 15) * 256 + frac;
    endfunction : levelLog

    // per-sample step toward target for a time constant given in 0.1 ms
    function automatic int timeAlpha(input int tenthMs);
        int n;
        n = tenthMs * SAMPLE_RATE_HZ / 10000;
        return clampInt(65536 / (n + 1), 1, COEF_MAX);
    endfunction : timeAlpha

    always_comb
    begin
        int lvl;
        int over;
        int slope;
        int ratio;
        int half;
        int target;
        int alpha;
        longint d;
        lvl = 0;
        over = 0;
        slope = 0;
        ratio = 0;
        half = KNEE_Q8 / 2;
        target = 0;
        alpha = 0;
        d = 0;
        st_nxt = st_r;
        if (sampleValid)
        begin
            lvl = (scL < 0 ? -int'(scL) : int'(scL)) + (scR < 0 ? -int'(scR) : int'(scR));
            over = levelLog(17'(lvl)) - dbToLog(clampInt(int'(thrTenthDb), GAIN_MIN_TENTH_DB, GAIN_MAX_TENTH_DB));
            ratio = int'(ratioTenths);
            if (ratio == RATIO_INF)
            begin
                slope = UNITY_Q8;
            end
            else
            begin
                ratio = clampInt(ratio, RATIO_MIN_TENTHS, RATIO_MAX_TENTHS);
                slope = UNITY_Q8 - (UNITY_Q8 * RATIO_MIN_TENTHS) / ratio;
            end
            if (over <= -half)
            begin
                target = 0;
            end
            else if (over >= half)
            begin
                target = (over * slope) >>> 8;
            end
            else
            begin
                // quadratic blend keeps slope continuous across the knee
                target = (slope * (over + half) * (over + half)) / (2 * KNEE_Q8 * 256);
            end
            target = target <<< 8;
            if (target > int'(st_r.env))
            begin
                alpha = timeAlpha(clampInt(int'(atkTenthMs), 0, ATK_MAX_TENTH_MS));
            end
            else
            begin
                alpha = timeAlpha(clampInt(int'(relMs), 0, REL_MAX_MS) * 10);
            end
            d = longint'(target) - longint'(st_r.env);
            st_nxt.env = 24'(longint'(st_r.env) + ((d * alpha) >>> 16));
            alpha = timeAlpha(clampInt(int'(smthTenthMs), 0, SMTH_MAX_TENTH_MS));
            d = longint'(st_nxt.env) - longint'(st_r.smth);
            st_nxt.smth = 24'(longint'(st_r.smth) + ((d * alpha) >>> 16));
            st_nxt.gainLog = 16'(-(int'(st_nxt.smth) >>> 8));
            st_nxt.grTenthDb = 12'(((int'(st_nxt.smth) >>> 8) * LOG_TO_DB_Q10) >>> 10);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign gainLog = st_r.gainLog;
    assign grTenthDb = st_r.grTenthDb;
endmodule : tbsc_band_comp

// ==== verilog/tbsc_compressor.sv ====
// stereo three-band soft-knee compressor with pre-delay and bypass
// Notes on behaviour
// - split into three bands, compress each, sum
// - two crossover frequencies, either may be higher
// - level is |left| plus |right|, common gain
// - slope above threshold is one over ratio
// - threshold in dB relative to full scale
// - soft knee around the threshold
// - per-band attack time up to 228 ms
// - per-band release time up to 3000 ms
// - per-band smoothing low-pass on gain control
// - side chain from input or from output
// - main path delayed up to 25 ms
// - per-band gain reduction reported for metering
// - bypass passes input through unprocessed
// - output gain ignored while bypassed
// - per-band post gain before summing
module tbsc_compressor
    import tbsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic signed [15:0] inL,
    input wire logic signed [15:0] inR,
    input wire logic compActive,
    input wire logic sideChainSourceSelect,
    input wire logic [7:0] sigDlyTenthMs,
    input wire logic [14:0] bandSplitFreqA,
    input wire logic [14:0] bandSplitFreqB,
    input wire logic outGainOff,
    input wire logic signed [10:0] outGainTenthDb,
    input wire logic [2:0][11:0] atkTenthMs,
    input wire logic [2:0][11:0] relMs,
    input wire logic [2:0][11:0] smthTenthMs,
    input wire logic [2:0][10:0] ratioTenths,
    input wire logic [2:0][10:0] thrTenthDb,
    input wire logic [2:0] bandPostGainOff,
    input wire logic [2:0][10:0] bandPostGainTenthDb,
    output logic signed [15:0] outL,
    output logic signed [15:0] outR,
    output logic outValid,
    output logic [2:0][11:0] grMeter
);
    typedef struct packed {
        logic [DLY_DEPTH-1:0][1:0][15:0] dly;
        logic [10:0] wp;
        logic [1:0][1:0][1:0][23:0] lp;
        logic [2:0][1:0][15:0] bandOut;
        logic signed [15:0] outL;
        logic signed [15:0] outR;
        logic outValid;
        logic [2:0][11:0] grMeter;
    } tbsc_top_state_t;

    tbsc_top_state_t st_r;
    tbsc_top_state_t st_nxt;
    logic [2:0][1:0][15:0] scBand;
    logic [2:0][1:0][15:0] liveBand;
    logic [2:0][15:0] gainLog;
    logic [2:0][11:0] grTenthDb;

    function automatic int splitCoef(input int f);
        return clampInt((clampInt(f, FREQ_MIN_HZ, FREQ_MAX_HZ) * COEF_SCALE_Q10) >>> 10, 1, COEF_MAX);
    endfunction : splitCoef

    // live input split, computed from the held filter state for the feed-forward side chain
    always_comb
    begin
        int lo;
        int hi;
        int x;
        logic signed [23:0] a;
        logic signed [23:0] b;
        lo = splitCoef(int'(bandSplitFreqA));
        hi = splitCoef(int'(bandSplitFreqB));
        if (lo > hi)
        begin
            lo = splitCoef(int'(bandSplitFreqB));
            hi = splitCoef(int'(bandSplitFreqA));
        end
        x = 0;
        a = '0;
        b = '0;
        liveBand = '0;
        for (int c = 0; c < 2; c++)
        begin
            x = (c == 0) ? int'(inL) : int'(inR);
            a = onePole(st_r.lp[0][c][0], x, lo);
            b = onePole(st_r.lp[0][c][1], x, hi);
            liveBand[0][c] = satS16(longint'(a >>> 8));
            liveBand[1][c] = satS16(longint'((b - a) >>> 8));
            liveBand[2][c] = satS16(longint'(x) - longint'(b >>> 8));
        end
        // feedback takes last sample's compressed band output
        scBand = sideChainSourceSelect ? st_r.bandOut : liveBand;
    end

    for (genvar g = 0; g < 3; g++)
    begin : gBand
        tbsc_band_comp uBand (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .sampleValid(sampleValid),
            .scL(scBand[g][0]),
            .scR(scBand[g][1]),
            .thrTenthDb(thrTenthDb[g]),
            .ratioTenths(ratioTenths[g]),
            .atkTenthMs(atkTenthMs[g]),
            .relMs(relMs[g]),
            .smthTenthMs(smthTenthMs[g]),
            .gainLog(gainLog[g]),
            .grTenthDb(grTenthDb[g])
        );
    end

    always_comb
    begin
        int dlyN;
        int rd;
        int lo;
        int hi;
        int x;
        int lg;
        longint g;
        longint og;
        longint y;
        longint sum;
        logic signed [23:0] a;
        logic signed [23:0] b;
        logic signed [1:0][15:0] dIn;
        st_nxt = st_r;
        st_nxt.outValid = 1'b0;
        dlyN = 0;
        rd = 0;
        x = 0;
        lg = 0;
        g = 0;
        og = 0;
        y = 0;
        sum = 0;
        a = '0;
        b = '0;
        dIn = '0;
        lo = splitCoef(int'(bandSplitFreqA));
        hi = splitCoef(int'(bandSplitFreqB));
        if (lo > hi)
        begin
            lo = splitCoef(int'(bandSplitFreqB));
            hi = splitCoef(int'(bandSplitFreqA));
        end
        if (sampleValid)
        begin
            dlyN = clampInt(int'(sigDlyTenthMs), 0, DLY_MAX_TENTH_MS) * SAMPLE_RATE_HZ / 10000;
            rd = int'(st_r.wp) - dlyN;
            if (rd < 0)
            begin
                rd = rd + DLY_DEPTH;
            end
            // zero delay must not read the slot being written this cycle
            dIn = (dlyN == 0) ? {inR, inL} : st_r.dly[rd];
            st_nxt.dly[st_r.wp] = {inR, inL};
            st_nxt.wp = (int'(st_r.wp) == DLY_DEPTH - 1) ? '0 : st_r.wp + 11'h001;
            for (int c = 0; c < 2; c++)
            begin
                st_nxt.lp[0][c][0] = onePole(st_r.lp[0][c][0], (c == 0) ? int'(inL) : int'(inR), lo);
                st_nxt.lp[0][c][1] = onePole(st_r.lp[0][c][1], (c == 0) ? int'(inL) : int'(inR), hi);
                x = int'(signed'(dIn[c]));
                a = onePole(st_r.lp[1][c][0], x, lo);
                b = onePole(st_r.lp[1][c][1], x, hi);
                st_nxt.lp[1][c][0] = a;
                st_nxt.lp[1][c][1] = b;
                sum = 0;
                for (int k = 0; k < 3; k++)
                begin
                    y = (k == 0) ? longint'(a >>> 8) : ((k == 1) ? longint'((b - a) >>> 8) : longint'(x) - (b >>> 8));
                    lg = int'(signed'(gainLog[k]));
                    lg = lg + dbToLog(clampInt(int'(signed'(bandPostGainTenthDb[k])), GAIN_MIN_TENTH_DB,
                        GAIN_MAX_TENTH_DB));
                    g = bandPostGainOff[k] ? 0 : exp2Lin(lg);
                    st_nxt.bandOut[k][c] = satS16((y * g) >>> 8);
                    sum = sum + longint'(signed'(st_nxt.bandOut[k][c]));
                end
                og = outGainOff ? 0 : exp2Lin(dbToLog(clampInt(int'(outGainTenthDb), GAIN_MIN_TENTH_DB,
                    GAIN_MAX_TENTH_DB)));
                y = (sum * og) >>> 8;
                if (!compActive)
                begin
                    y = (c == 0) ? longint'(inL) : longint'(inR);
                end
                if (c == 0)
                begin
                    st_nxt.outL = satS16(y);
                end
                else
                begin
                    st_nxt.outR = satS16(y);
                end
            end
            st_nxt.outValid = 1'b1;
            st_nxt.grMeter = grTenthDb;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign outL = st_r.outL;
    assign outR = st_r.outR;
    assign outValid = st_r.outValid;
    assign grMeter = st_r.grMeter;
endmodule : tbsc_compressor

// ==== verif/tbsc_compressor_monitor.sv ====
// port-level checks for the three-band compressor
module tbsc_compressor_monitor
    import tbsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic sampleValid,
    input wire logic signed [15:0] inL,
    input wire logic signed [15:0] inR,
    input wire logic compActive,
    input wire logic outGainOff,
    input wire logic [2:0] bandPostGainOff,
    input wire logic signed [15:0] outL,
    input wire logic signed [15:0] outR,
    input wire logic outValid,
    input wire logic [2:0][11:0] grMeter
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence taken;
        sampleValid ##1 !sampleValid;
    endsequence
    sequence pulse;
        outValid ##1 !outValid;
    endsequence

    strobe_width_a: assert property (taken |-> pulse)
        else $error("output strobe not one cycle wide");
    strobe_cause_a: assert property (outValid |-> $past(sampleValid))
        else $error("output strobe without a sample");
    // a one-edge reset may clear the outputs without a strobe
    out_hold_a: assert property (!outValid && $past(rst_b) |-> $stable({outL, outR}))
        else $error("output moved between strobes");
    meter_hold_a: assert property (!outValid && $past(rst_b) |-> $stable(grMeter))
        else $error("meter moved between strobes");
    bypass_pass_a: assert property (sampleValid && !compActive |=> {outL, outR} == $past({inL, inR}))
        else $error("bypass output differs from input");
    gain_off_a: assert property (sampleValid && compActive && outGainOff |=> {outL, outR} == 32'h0)
        else $error("output gain off is not silent");
    bands_off_a: assert property (sampleValid && compActive && (&bandPostGainOff) |=> {outL, outR} == 32'h0)
        else $error("all bands off is not silent");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !outValid && {outL, outR} == 32'h0 && grMeter == 36'h0)
        else $error("outputs not cleared by reset");
endmodule : tbsc_compressor_monitor

// ==== verif/tbsc_stream_model.sv ====
// upstream sample source and downstream capture around the compressor
module tbsc_stream_model
(
    input wire logic clk_sys,
    input wire logic [31:0] quota,
    input wire logic [3:0] gap,
    input wire logic signed [15:0] lvlL,
    input wire logic signed [15:0] lvlR,
    input wire logic outValid,
    input wire logic signed [15:0] outL,
    input wire logic signed [15:0] outR,
    output logic sampleValid = 1'b0,
    output logic signed [15:0] inL = 16'h0000,
    output logic signed [15:0] inR = 16'h0000,
    output logic signed [15:0] capL = 16'h0000,
    output logic signed [15:0] capR = 16'h0000,
    output logic [31:0] capCount = 32'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    int sent = 0;
    int idle = 0;
    logic go;
    logic signed [15:0] nL, nR;

    // capture mid-cycle, clear of the edge that launches the outputs
    always @(negedge clk_sys)
    begin
        if (outValid === 1'b1)
        begin
            capL = outL;
            capR = outR;
            capCount = capCount + 1;
        end
    end

    always @(posedge clk_sys)
    begin
        go = (sent < quota) && (idle >= gap);
        nL = lvlL;
        nR = lvlR;
        #1;
        sampleValid = go;
        // churn between frames so a stale sample never looks valid
        inL = go ? nL : ~inL;
        inR = go ? nR : ~inR;
        sent = sent + go;
        idle = go ? 0 : idle + 1;
    end
endmodule : tbsc_stream_model

// ==== verif/tbsc_compressor_tb.sv ====
// self-checking bench for the three-band compressor
module tbsc_compressor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rst_b = 1'b0, sampleValid, outValid;
    logic signed [15:0] inL, inR, outL, outR, capL, capR;
    logic signed [15:0] lvlL = 16'h0000, lvlR = 16'h0000;
    logic compActive = 1'b1, sideChainSourceSelect = 1'b0, outGainOff = 1'b0;
    logic [7:0] sigDlyTenthMs = 8'h00;
    logic [14:0] bandSplitFreqA = 15'h4e20, bandSplitFreqB = 15'h00c8;
    logic signed [10:0] outGainTenthDb = 11'h000;
    logic [2:0][11:0] atkTenthMs = 36'h0, relMs = 36'h0;
    logic [2:0][11:0] smthTenthMs = 36'h0;
    logic [2:0][10:0] ratioTenths = {3{11'h00a}}, thrTenthDb = {3{11'h0f0}};
    logic [2:0][10:0] bandPostGainTenthDb = 33'h0;
    logic [2:0] bandPostGainOff = 3'h0;
    logic [2:0][11:0] grMeter;
    logic [31:0] quota = 32'h0, capCount;
    logic [3:0] gap = 4'h0;
    int fails = 0, checked = 0, i, e;
    int ogT[5] = '{60, 0, 60, 240, -790};
    int bgT[5] = '{0, -60, -60, 0, 0};
    int ratT[4] = '{10, 20, 0, 20};
    int grT[4] = '{0, 99, 198, 66};
    // threshold, attack, release, smoothing, samples, expected reduction
    int tmT[7][6] = '{'{-200, 0, 0, 0, 50, 198}, '{240, 0, 3000, 0, 10, 198}, '{240, 0, 0, 0, 10, 0},
        '{-200, 2280, 0, 0, 10, 0}, '{-200, 0, 0, 0, 3, 198}, '{240, 0, 0, 0, 10, 0}, '{-200, 0, 0, 2280, 10, 0}};

    tbsc_compressor i_dut (.clk_sys, .rst_b, .sampleValid, .inL, .inR, .compActive, .sideChainSourceSelect,
        .sigDlyTenthMs, .bandSplitFreqA, .bandSplitFreqB, .outGainOff, .outGainTenthDb, .atkTenthMs, .relMs,
        .smthTenthMs, .ratioTenths, .thrTenthDb, .bandPostGainOff, .bandPostGainTenthDb, .outL, .outR,
        .outValid, .grMeter);
    tbsc_stream_model i_src (.clk_sys, .quota, .gap, .lvlL, .lvlR, .outValid, .outL, .outR, .sampleValid,
        .inL, .inR, .capL, .capR, .capCount);

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic near(input logic signed [16:0] got, input int exp, input int tol, input string what);
        checked++;
        if ((^got === 1'bx) || int'(got) > exp + tol || int'(got) < exp - tol)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : near

    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // runs exactly n frames and waits until all of them came back
    task automatic play(input int n, input logic signed [15:0] l, input logic signed [15:0] r);
        int k;
        lvlL = l;
        lvlR = r;
        quota = quota + n;
        for (k = 0; k < 40 * n + 40 && capCount < quota; k++)
        begin
            @(posedge clk_sys);
            #1;
        end
        if (capCount !== quota)
        begin
            fails++;
            $display("CHECK FAILED at %0t: output stream stalled", $time);
            results();
        end
    endtask : play

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        for (i = 0; i < 40; i++)
        begin
            bandSplitFreqA = (i < 20) ? 15'h4e20 : 15'h00c8;
            bandSplitFreqB = (i < 20) ? 15'h00c8 : 15'h4e20;
            play(1, i[0] ? 16'h1f40 : 16'he0c0, 16'h07d0);
            near(capL, i[0] ? 8000 : -8000, 8, "band sum");
        end
        sigDlyTenthMs = 8'h0a;
        for (i = 0; i < 2; i++)
        begin
            sideChainSourceSelect = i[0];
            play(60, 16'h0000, 16'h0000);
            play(48, 16'h1f40, 16'h1f40);
            near(capL, 0, 8, "delayed step early");
            play(1, 16'h1f40, 16'h1f40);
            near(capL, 8000, 8, "delayed step due");
        end
        sigDlyTenthMs = 8'h00;
        gap = 4'h3;
        compActive = 1'b0;
        outGainTenthDb = 11'h0f0;
        play(2, 16'h04d2, 16'hef1f);
        near(capL, 1234, 0, "bypass left");
        near(capR, -4321, 0, "bypass right");
        compActive = 1'b1;
        for (i = 0; i < 7; i++)
        begin
            outGainTenthDb = 11'(ogT[i % 5]);
            bandPostGainTenthDb = {3{11'(bgT[i % 5])}};
            outGainOff = (i == 5);
            bandPostGainOff = {3{i == 6}};
            e = (i > 4) ? 0 : int'(2000.0 * 10.0 ** ((ogT[i % 5] + bgT[i % 5]) / 200.0));
            play(4, 16'h07d0, 16'h07d0);
            near(capL, e, e / 50 + 4, "gain");
        end
        {outGainTenthDb, bandPostGainTenthDb, outGainOff, bandPostGainOff} = 48'h0;
        thrTenthDb = {3{11'h738}};
        for (i = 0; i < 4; i++)
        begin
            ratioTenths = {3{11'(ratT[i])}};
            sideChainSourceSelect = (i == 3);
            bandSplitFreqA = i[0] ? 15'h4e20 : 15'h00c8;
            bandSplitFreqB = i[0] ? 15'h00c8 : 15'h4e20;
            play(400, 16'h3e80, 16'hc180);
            near(grMeter[0], grT[i], 15, "low band reduction");
            near(grMeter[2], 0, 10, "high band idle");
            e = int'(16000.0 * 10.0 ** (-grT[i] / 200.0));
            near(capL, e, e / 10 + 8, "common gain left");
            near(capR, -e, e / 10 + 8, "common gain right");
        end
        sideChainSourceSelect = 1'b0;
        ratioTenths = {3{11'h000}};
        for (i = 0; i < 7; i++)
        begin
            thrTenthDb = {3{11'(tmT[i][0])}};
            atkTenthMs = {3{12'(tmT[i][1])}};
            relMs = {3{12'(tmT[i][2])}};
            smthTenthMs = {3{12'(tmT[i][3])}};
            play(tmT[i][4], 16'h3e80, 16'hc180);
            near(grMeter[0], tmT[i][5], 15, "ballistics");
        end
        // alternating half-scale tone lands in the mid band only
        smthTenthMs = 36'h0;
        play(400, 16'h0000, 16'h0000);
        for (i = 0; i < 20; i++)
        begin
            play(1, i[0] ? 16'h3e80 : 16'hc180, i[0] ? 16'hc180 : 16'h3e80);
        end
        near(grMeter[1], 196, 15, "mid band reduction");
        near(grMeter[0], 0, 10, "low band idle");
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        near(outL, 0, 0, "reset output");
        near(grMeter[0], 0, 0, "reset meter");
        rst_b = 1'b1;
        play(4, 16'h07d0, 16'h07d0);
        results();
    end
endmodule : tbsc_compressor_tb

bind tbsc_compressor tbsc_compressor_monitor i_mon (.clk_sys, .rst_b, .sampleValid, .inL, .inR, .compActive,
    .outGainOff, .bandPostGainOff, .outL, .outR, .outValid, .grMeter);
